// ==== logic/pan_pkg.sv ====
// Shared constants for the auto-negotiation status and interrupt register bank.
// Assumes a single device clock and a management port decoded to register indices.
package pan_pkg;

    // ****************************************
    // Register indices on the management port
    // ****************************************
    localparam logic [4:0] REG_AN_STATUS_IDX = 5'h19;
    localparam logic [4:0] REG_INT_CTRL_IDX = 5'h1A;

    // ****************************************
    // Auto-negotiation status register fields
    // ****************************************
    localparam int AN_DONE_BIT = 15;
    localparam int AN_ACK_DONE_BIT = 14;
    localparam int AN_ACK_ENTER_BIT = 13;
    localparam int AN_LP_ABILITY_BIT = 12;
    localparam int AN_PAUSE_BIT = 11;
    localparam int AN_HCM_LSB = 8;
    localparam int AN_PD_FAULT_BIT = 7;
    localparam int AN_FAR_FAULT_BIT = 6;
    localparam int AN_PAGE_RX_BIT = 5;
    localparam int AN_LP_AN_ABLE_BIT = 4;
    localparam int AN_FAST_BIT = 3;
    localparam int AN_LINK_BIT = 2;
    localparam int AN_ENABLE_BIT = 1;
    localparam int AN_JABBER_BIT = 0;

    // ****************************************
    // Interrupt / LED control register fields
    // ****************************************
    localparam int INT_FDX_LED_BIT = 15;
    localparam int INT_MODE_BIT = 14;
    localparam int INT_RSVD_LSB = 12;
    localparam int INT_FDX_MASK_BIT = 11;
    localparam int INT_SPD_MASK_BIT = 10;
    localparam int INT_LINK_MASK_BIT = 9;
    localparam int INT_MASTER_MASK_BIT = 8;
    localparam int INT_GLOBAL_BIT = 4;
    localparam int INT_FDX_CHG_BIT = 3;
    localparam int INT_SPD_CHG_BIT = 2;
    localparam int INT_LINK_CHG_BIT = 1;
    localparam int INT_STATUS_BIT = 0;
    localparam logic [15:0] INT_CTRL_RST = 16'h0F00;

    // ****************************************
    // Highest common mode codes
    // ****************************************
    localparam logic [2:0] HCM_NONE = 3'h0;
    localparam logic [2:0] HCM_10_HALF = 3'h1;
    localparam logic [2:0] HCM_10_FULL = 3'h2;
    localparam logic [2:0] HCM_100_HALF = 3'h3;
    localparam logic [2:0] HCM_100_T4 = 3'h4;
    localparam logic [2:0] HCM_100_FULL = 3'h5;

    // ****************************************
    // LED pin modes
    // ****************************************
    localparam logic [1:0] LED_MODE_NORMAL = 2'h0;
    localparam logic [1:0] LED_MODE_IRQ_OUT_N = 2'h1;
    localparam logic [1:0] LED_MODE_FDX = 2'h2;

endpackage

// ==== logic/pan_chg_if.sv ====
// Change events from the line-state watcher to the register bank.
// Assumes both ends share the device clock.
`timescale 1ns/1ps
`default_nettype none
interface pan_chg_if;
    logic dup_chg;
    logic spd_chg;
    logic link_chg;
    modport src (output dup_chg, output spd_chg, output link_chg);
    modport dst (input dup_chg, input spd_chg, input link_chg);
endinterface
`default_nettype wire

// ==== logic/pan_chg_det.sv ====
// Watches duplex, speed and link levels and pulses one cycle on each change.
// Assumes level inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pan_chg_det (
    input wire logic sys_clk, // Device clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic full_duplex, // Current duplex level
    input wire logic fast_speed_flag, // Current speed level, 1 = 100 Mb
    input wire logic link_ok, // Current link level
    pan_chg_if.src chg // Change pulses
);
    typedef struct packed {
        logic primed;
        logic dup;
        logic speed_sel;
        logic lnk;
        logic dup_p;
        logic spd_p;
        logic lnk_p;
    } pan_det_state_t;

    pan_det_state_t st_reg;
    pan_det_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.primed = 1'b1;
        st_next.dup = full_duplex;
        st_next.speed_sel = fast_speed_flag;
        st_next.lnk = link_ok;
        // First cycle only records levels, so reset release is not a change
        st_next.dup_p = st_reg.primed && (full_duplex != st_reg.dup); // see R19
        st_next.spd_p = st_reg.primed && (fast_speed_flag != st_reg.speed_sel); // see R20
        st_next.lnk_p = st_reg.primed && (link_ok != st_reg.lnk); // see R21
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign chg.dup_chg = st_reg.dup_p;
    assign chg.spd_chg = st_reg.spd_p;
    assign chg.link_chg = st_reg.lnk_p;
endmodule // pan_chg_det
`default_nettype wire

// ==== logic/pan_led_mux.sv ====
// Routes LED sources onto the two LED pins according to the LED mode.
// Assumes active-low LED sources synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pan_led_mux (
    input wire logic sys_clk, // Device clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic fdx_led_en, // Full-duplex LED mode
    input wire logic int_mode_en, // Interrupt mode
    input wire logic irq_n, // Interrupt level, active low
    input wire logic tx_src_n, // Transmit LED source
    input wire logic rx_src_n, // Receive LED source
    input wire logic fdx_src_n, // Full-duplex LED source
    input wire logic activity_led_n, // Activity LED source
    output logic tx_led_n, // Transmit LED pin
    output logic rx_led_n, // Receive LED pin
    output logic [1:0] led_mode // Selected serial LED source set
);
    typedef struct packed {
        logic tx;
        logic rx;
        logic [1:0] mode;
    } pan_led_state_t;

    pan_led_state_t st_reg;
    pan_led_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // Full-duplex mode wins if software breaks the exclusion
        if (fdx_led_en) begin // see R13
            st_next.mode = pan_pkg::LED_MODE_FDX;
            st_next.tx = fdx_src_n;
            st_next.rx = activity_led_n;
        end else if (int_mode_en) begin // see R25
            st_next.mode = pan_pkg::LED_MODE_IRQ_OUT_N;
            st_next.tx = irq_n;
            st_next.rx = activity_led_n;
        end else begin
            st_next.mode = pan_pkg::LED_MODE_NORMAL;
            st_next.tx = tx_src_n;
            st_next.rx = rx_src_n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= '{tx: 1'b1, rx: 1'b1, mode: 2'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_led_n = st_reg.tx;
    assign rx_led_n = st_reg.rx;
    assign led_mode = st_reg.mode;
endmodule // pan_led_mux
`default_nettype wire

// ==== logic/pan_regs.sv ====
// Auto-negotiation result status and interrupt/LED control register bank.
// Assumes a management framer that decodes register index, read and write strobes.
//
// Contract
// R1 - Report highest common mode, 11x undefined
// R2 - Completion bit set when done, reset zero
// R3 - Latched-high completed-acknowledge bit
// R4 - Latched-high acknowledge-entered bit
// R5 - Latched-high partner ability detected bit
// R6 - Pause bit only when both sides pause
// R7 - Latch high parallel detection fault
// R8 - Latch high remote far-end fault
// R9 - Latch high new page received
// R10 - Latch high partner supports negotiation
// R11 - Latched bits hold until cleared, reset zero
// R12 - Software never sets both LED modes
// R13 - LED mode bits select serial LED data
// R14 - Duplex mask blocks interrupt, resets one
// R15 - Speed mask blocks interrupt, resets one
// R16 - Link mask blocks interrupt, resets one
// R17 - Master mask suppresses all, resets one
// R18 - Global flag shows any event detected
// R19 - Latch high duplex change flag
// R20 - Latch high speed change flag
// R21 - Latch high link change flag
// R22 - Status bit mirrors interrupt pin, latched
// R23 - Interrupt register read clears change flags
// R24 - Interrupt status needs master off, flag set
// R25 - Interrupt mode remaps transmit and receive LEDs
// R26 - Link status latched low until read
`timescale 1ns/1ps
`default_nettype none
module pan_regs (
    input wire logic sys_clk, // Device clock, 50 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [4:0] mgmt_addr, // Register index
    input wire logic mgmt_rd, // Read strobe, one cycle
    input wire logic mgmt_wr, // Write strobe, one cycle
    input wire logic [15:0] mgmt_wdata, // Write data
    output logic [15:0] mgmt_rdata, // Read data
    output logic mgmt_rvalid, // Read data valid pulse
    input wire logic an_complete, // Negotiation finished level
    input wire logic an_ack_done, // Completed-acknowledge reached pulse
    input wire logic an_ack_enter, // Acknowledge phase entered pulse
    input wire logic lp_ability_det, // Partner ability detected pulse
    input wire logic local_side_pause, // Local pause capability
    input wire logic remote_partner_pause, // Remote pause capability
    input wire logic [2:0] highest_common_mode, // Resolved mode code
    input wire logic pd_fault, // Parallel detection fault pulse
    input wire logic far_end_fault, // Remote far-end fault pulse
    input wire logic page_rx, // New page received pulse
    input wire logic lp_an_able, // Partner negotiation capable pulse
    input wire logic fast_speed_flag, // Speed level, 1 = 100 Mb
    input wire logic full_duplex, // Duplex level
    input wire logic link_ok, // Link pass level
    input wire logic an_enabled, // Negotiation enabled level
    input wire logic jabber_det, // Jabber detected pulse
    input wire logic tx_src_n, // Transmit LED source
    input wire logic rx_src_n, // Receive LED source
    input wire logic fdx_src_n, // Full-duplex LED source
    input wire logic activity_led_n, // Activity LED source
    output logic irq_out_n, // Interrupt level, active low
    output logic tx_led_n, // Transmit LED pin
    output logic rx_led_n, // Receive LED pin
    output logic [1:0] led_mode // Serial LED source set
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic an_done;
        logic ack_done;
        logic ack_enter;
        logic lp_ability;
        logic pause;
        logic [2:0] hcm;
        logic pd_fault;
        logic far_fault;
        logic page_rx;
        logic lp_an_able;
        logic fast;
        logic link_ll;
        logic an_en;
        logic jabber;
        logic fdx_led_en;
        logic int_mode_en;
        logic [1:0] rsvd_rw;
        logic fdx_mask;
        logic spd_mask;
        logic link_mask;
        logic master_mask;
        logic fdx_chg;
        logic spd_chg;
        logic link_chg;
        logic int_stat;
        logic irq_n;
        logic [15:0] rdata;
        logic rvalid;
    } pan_top_state_t;

    pan_top_state_t st_reg;
    pan_top_state_t st_next;
    pan_chg_if chg_bus ();

    // ****************************************
    // Read word assembly
    // ****************************************
    function automatic logic [15:0] pan_status_word(input pan_top_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[pan_pkg::AN_DONE_BIT] = s.an_done;
        w[pan_pkg::AN_ACK_DONE_BIT] = s.ack_done;
        w[pan_pkg::AN_ACK_ENTER_BIT] = s.ack_enter;
        w[pan_pkg::AN_LP_ABILITY_BIT] = s.lp_ability;
        w[pan_pkg::AN_PAUSE_BIT] = s.pause;
        w[pan_pkg::AN_HCM_LSB +: 3] = s.hcm;
        w[pan_pkg::AN_PD_FAULT_BIT] = s.pd_fault;
        w[pan_pkg::AN_FAR_FAULT_BIT] = s.far_fault;
        w[pan_pkg::AN_PAGE_RX_BIT] = s.page_rx;
        w[pan_pkg::AN_LP_AN_ABLE_BIT] = s.lp_an_able;
        w[pan_pkg::AN_FAST_BIT] = s.fast;
        w[pan_pkg::AN_LINK_BIT] = s.link_ll;
        w[pan_pkg::AN_ENABLE_BIT] = s.an_en;
        w[pan_pkg::AN_JABBER_BIT] = s.jabber;
        return w;
    endfunction

    function automatic logic [15:0] pan_int_word(input pan_top_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[pan_pkg::INT_FDX_LED_BIT] = s.fdx_led_en;
        w[pan_pkg::INT_MODE_BIT] = s.int_mode_en;
        w[pan_pkg::INT_RSVD_LSB +: 2] = s.rsvd_rw;
        w[pan_pkg::INT_FDX_MASK_BIT] = s.fdx_mask;
        w[pan_pkg::INT_SPD_MASK_BIT] = s.spd_mask;
        w[pan_pkg::INT_LINK_MASK_BIT] = s.link_mask;
        w[pan_pkg::INT_MASTER_MASK_BIT] = s.master_mask;
        w[pan_pkg::INT_GLOBAL_BIT] = s.fdx_chg | s.spd_chg | s.link_chg; // see R18
        w[pan_pkg::INT_FDX_CHG_BIT] = s.fdx_chg;
        w[pan_pkg::INT_SPD_CHG_BIT] = s.spd_chg;
        w[pan_pkg::INT_LINK_CHG_BIT] = s.link_chg;
        w[pan_pkg::INT_STATUS_BIT] = s.int_stat;
        return w;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic rd_status;
    logic rd_int;
    logic wr_int;
    logic irq_want;

    always_comb begin
        rd_status = mgmt_rd && (mgmt_addr == pan_pkg::REG_AN_STATUS_IDX);
        rd_int = mgmt_rd && (mgmt_addr == pan_pkg::REG_INT_CTRL_IDX);
        wr_int = mgmt_wr && (mgmt_addr == pan_pkg::REG_INT_CTRL_IDX);
        st_next = st_reg;

        // Plain status levels
        st_next.an_done = an_complete; // see R2
        st_next.pause = local_side_pause & remote_partner_pause; // see R6
        // Undefined codes read as no common mode
        st_next.hcm = highest_common_mode[2:1] == 2'h3 ? pan_pkg::HCM_NONE
                                                     : highest_common_mode; // see R1
        st_next.fast = fast_speed_flag;
        st_next.an_en = an_enabled;

        // Latched-high bits: a read clears, an event in the same cycle wins
        st_next.ack_done = (st_reg.ack_done & ~rd_status) | an_ack_done; // see R3, R11
        st_next.ack_enter = (st_reg.ack_enter & ~rd_status) | an_ack_enter; // see R4, R11
        st_next.lp_ability = (st_reg.lp_ability & ~rd_status) | lp_ability_det; // see R5
        st_next.pd_fault = (st_reg.pd_fault & ~rd_status) | pd_fault; // see R7
        st_next.far_fault = (st_reg.far_fault & ~rd_status) | far_end_fault; // see R8
        st_next.page_rx = (st_reg.page_rx & ~rd_status) | page_rx; // see R9
        st_next.lp_an_able = (st_reg.lp_an_able & ~rd_status) | lp_an_able; // see R10
        st_next.jabber = (st_reg.jabber & ~rd_status) | jabber_det; // see R11

        // Latched low: a read reloads the live level, a failure always wins
        st_next.link_ll = (rd_status ? 1'b1 : st_reg.link_ll) & link_ok; // see R26

        // Control fields
        if (wr_int) begin
            st_next.fdx_led_en = mgmt_wdata[pan_pkg::INT_FDX_LED_BIT]; // see R13
            st_next.int_mode_en = mgmt_wdata[pan_pkg::INT_MODE_BIT]; // see R13
            st_next.rsvd_rw = mgmt_wdata[pan_pkg::INT_RSVD_LSB +: 2];
            st_next.fdx_mask = mgmt_wdata[pan_pkg::INT_FDX_MASK_BIT]; // see R14
            st_next.spd_mask = mgmt_wdata[pan_pkg::INT_SPD_MASK_BIT]; // see R15
            st_next.link_mask = mgmt_wdata[pan_pkg::INT_LINK_MASK_BIT]; // see R16
            st_next.master_mask = mgmt_wdata[pan_pkg::INT_MASTER_MASK_BIT]; // see R17
        end

        // Change flags latch whatever the masks hold; masks gate only the pin
        st_next.fdx_chg = (st_reg.fdx_chg & ~rd_int) | chg_bus.dup_chg; // see R19, R23
        st_next.spd_chg = (st_reg.spd_chg & ~rd_int) | chg_bus.spd_chg; // see R20, R23
        st_next.link_chg = (st_reg.link_chg & ~rd_int) | chg_bus.link_chg; // see R21, R23

        irq_want = ~st_reg.master_mask & // see R17, R24
                   ((st_reg.fdx_chg & ~st_reg.fdx_mask) | // see R14
                    (st_reg.spd_chg & ~st_reg.spd_mask) | // see R15
                    (st_reg.link_chg & ~st_reg.link_mask)); // see R16
        st_next.irq_n = ~irq_want;
        // Follows the pin as driven, so it lags the pin by one cycle and the flags by two
        st_next.int_stat = (st_reg.int_stat & ~rd_int) | ~st_reg.irq_n; // see R22, R23

        // Read data reflects values before the read's own clear
        st_next.rvalid = rd_status | rd_int;
        if (rd_status) begin
            st_next.rdata = pan_status_word(st_reg);
        end else if (rd_int) begin
            st_next.rdata = pan_int_word(st_reg);
        end else begin
            st_next.rdata = 16'h0000;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.fdx_mask <= pan_pkg::INT_CTRL_RST[pan_pkg::INT_FDX_MASK_BIT]; // see R14
            st_reg.spd_mask <= pan_pkg::INT_CTRL_RST[pan_pkg::INT_SPD_MASK_BIT]; // see R15
            st_reg.link_mask <= pan_pkg::INT_CTRL_RST[pan_pkg::INT_LINK_MASK_BIT]; // see R16
            st_reg.master_mask <= pan_pkg::INT_CTRL_RST[pan_pkg::INT_MASTER_MASK_BIT];
            st_reg.irq_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Submodules
    // ****************************************
    pan_chg_det u_chg_det (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .full_duplex(full_duplex),
        .fast_speed_flag(fast_speed_flag),
        .link_ok(link_ok),
        .chg(chg_bus)
    );

    // Software is trusted to keep the two LED modes exclusive; see R12
    pan_led_mux u_led_mux (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .fdx_led_en(st_reg.fdx_led_en),
        .int_mode_en(st_reg.int_mode_en),
        .irq_n(st_reg.irq_n),
        .tx_src_n(tx_src_n),
        .rx_src_n(rx_src_n),
        .fdx_src_n(fdx_src_n),
        .activity_led_n(activity_led_n),
        .tx_led_n(tx_led_n),
        .rx_led_n(rx_led_n),
        .led_mode(led_mode)
    );

    assign mgmt_rdata = st_reg.rdata;
    assign mgmt_rvalid = st_reg.rvalid;
    assign irq_out_n = st_reg.irq_n;
endmodule // pan_regs
`default_nettype wire

// ==== sim/pan_regs_checker.sv ====
// Port assertions for the register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pan_regs_checker (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic [4:0] mgmt_addr, // Index
    input wire logic mgmt_rd, // Read strobe
    input wire logic [15:0] mgmt_rdata, // Read data
    input wire logic mgmt_rvalid, // Answer
    input wire logic an_complete, // Done level
    input wire logic local_side_pause, // Pause
    input wire logic remote_partner_pause, // Pause
    input wire logic [2:0] highest_common_mode, // Mode
    input wire logic pd_fault, // Fault
    input wire logic link_ok, // Link
    input wire logic irq_out_n, // Pin
    input wire logic tx_led_n, // Pin
    input wire logic rx_led_n, // Pin
    input wire logic activity_led_n, // Source
    input wire logic [1:0] led_mode // Mode
);
    logic st_rd;
    logic ic_rd;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    assign st_rd = mgmt_rd && mgmt_addr == pan_pkg::REG_AN_STATUS_IDX;
    assign ic_rd = mgmt_rd && mgmt_addr == pan_pkg::REG_INT_CTRL_IDX;
    // ********
    // Checks
    // ********
    read_answer_a: assert property ((st_rd || ic_rd) |=> mgmt_rvalid)
        else $error("read not answered");
    answer_cause_a: assert property (mgmt_rvalid |-> $past(st_rd) || $past(ic_rd))
        else $error("answer without read");
    idle_data_a: assert property (!mgmt_rvalid |-> mgmt_rdata == 16'h0000)
        else $error("read data not idle");
    done_bit_a: assert property (st_rd && an_complete && $past(an_complete) && $past(resetn)
        |=> mgmt_rdata[15])
        else $error("done bit missing");
    pause_bit_a: assert property (st_rd && $stable(local_side_pause)
        && $stable(remote_partner_pause) && $past(resetn)
        |=> mgmt_rdata[11] == ($past(local_side_pause) && $past(remote_partner_pause)))
        else $error("pause bit wrong");
    mode_code_a: assert property (st_rd && $stable(highest_common_mode) && $past(resetn)
        |=> mgmt_rdata[10:8] == (($past(highest_common_mode) > 3'h5) ? 3'h0
        : $past(highest_common_mode)))
        else $error("mode code wrong");
    fault_latch_a: assert property (pd_fault ##1 st_rd |=> mgmt_rdata[7])
        else $error("fault not latched");
    link_low_a: assert property (!link_ok ##1 st_rd |=> !mgmt_rdata[2])
        else $error("link not latched low");
    global_or_a: assert property (ic_rd |=> mgmt_rdata[4] == |mgmt_rdata[3:1])
        else $error("global flag wrong");
    irq_status_a: assert property (ic_rd && !irq_out_n && !$past(irq_out_n)
        |=> mgmt_rdata[0] && mgmt_rdata[4])
        else $error("interrupt status missing");
    led_irq_a: assert property (led_mode == pan_pkg::LED_MODE_IRQ_OUT_N |-> tx_led_n == $past(irq_out_n)
        && rx_led_n == $past(activity_led_n))
        else $error("interrupt mode pins wrong");
endmodule // pan_regs_checker
bind pan_regs pan_regs_checker pan_regs_checker_inst (.*);
`default_nettype wire

// ==== sim/pan_sta_mgr.sv ====
// Management controller model issuing register reads and writes.
// Assumes a one-cycle answer after the read edge.
`timescale 1ns/1ps
`default_nettype none
module pan_sta_mgr (
    input wire logic sys_clk, // Clock
    input wire logic [15:0] mgmt_rdata, // Read data
    input wire logic mgmt_rvalid, // Answer
    output logic [4:0] mgmt_addr, // Index
    output logic mgmt_rd, // Read strobe
    output logic mgmt_wr, // Write strobe
    output logic [15:0] mgmt_wdata // Write data
);
    initial begin
        mgmt_addr = 5'h00;
        mgmt_rd = 1'b0;
        mgmt_wr = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    // Released lines show inverted leftovers, never the old value
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge sys_clk);
        mgmt_wr <= 1'b0;
        mgmt_addr <= ~a;
        mgmt_wdata <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(posedge sys_clk);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge sys_clk);
        mgmt_rd <= 1'b0;
        mgmt_addr <= ~a;
        @(negedge sys_clk);
        ok = mgmt_rvalid;
        d = mgmt_rdata;
    endtask
endmodule // pan_sta_mgr
`default_nettype wire

// ==== sim/pan_regs_tb.sv ====
// Self-checking bench with a reference model of both registers.
// Assumes pan_sta_mgr as management master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pan_regs_tb;
    logic sys_clk, resetn, mgmt_rd, mgmt_wr, mgmt_rvalid, ok;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, d, m_lh, m_ctl;
    logic an_complete, an_enabled, local_side_pause, remote_partner_pause;
    logic an_ack_done, an_ack_enter, lp_ability_det, pd_fault, far_end_fault, page_rx;
    logic lp_an_able, jabber_det, full_duplex, fast_speed_flag, link_ok, m_link;
    logic tx_src_n, rx_src_n, fdx_src_n, activity_led_n, irq_out_n, tx_led_n, rx_led_n;
    logic [7:0] ev;
    logic [2:0] lv, highest_common_mode;
    logic [3:1] m_flg;
    logic [1:0] led_mode;
    logic [31:0] rs;
    int fails;
    int n_checks;
    assign {an_ack_done, an_ack_enter, lp_ability_det, pd_fault, far_end_fault, page_rx,
        lp_an_able, jabber_det} = ev;
    assign {link_ok, fast_speed_flag, full_duplex} = lv;
    pan_regs pan_regs_inst (.*);
    pan_sta_mgr pan_sta_mgr_inst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // ********
    // Model and helpers
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic rq(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        pan_sta_mgr_inst.rd(a, d, ok);
        chk("rvalid", {15'h0, ok}, 16'h0001);
        chk("rdata", d & m, e & m);
    endtask
    task automatic sr;
        rq(pan_pkg::REG_AN_STATUS_IDX, {an_complete, m_lh[14:12], local_side_pause &
            remote_partner_pause, (highest_common_mode > 3'h5) ? 3'h0 : highest_common_mode,
            m_lh[7:4], fast_speed_flag, m_link, an_enabled, m_lh[0]}, 16'hFFFF);
        m_lh = 16'h0000;
        m_link = link_ok;
    endtask
    task automatic ir(input logic b0, input logic [15:0] m);
        rq(pan_pkg::REG_INT_CTRL_IDX, {m_ctl[15:8], 3'h0, |m_flg, m_flg, b0}, m);
        m_flg = 3'h0;
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 8'h00;
        m_lh = m_lh | {1'b0, m[7:5], 4'h0, m[4:1], 3'h0, m[0]};
        cyc(2);
    endtask
    task automatic tog(input int i);
        @(posedge sys_clk);
        if (i == 2 && lv[2]) m_link = 1'b0;
        lv[i] <= ~lv[i];
        m_flg[3 - i] = 1'b1;
        cyc(5);
    endtask
    task automatic wc(input logic [15:0] v);
        pan_sta_mgr_inst.wr(pan_pkg::REG_INT_CTRL_IDX, v);
        m_ctl = v & 16'hFF00;
        cyc(2);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        cyc(5000);
        fails++;
        conclude();
    end
    // ********
    // Scenarios
    // ********
    initial begin
        {resetn, an_complete, an_enabled, local_side_pause, remote_partner_pause} = 5'h00;
        {ev, lv, highest_common_mode, m_flg, m_link, m_lh} = {8'h00, 3'h4, 3'h0, 3'h0, 1'b0, 16'h0};
        {tx_src_n, rx_src_n, fdx_src_n, activity_led_n} = 4'hF;
        rs = 32'h0150;
        m_ctl = pan_pkg::INT_CTRL_RST;
        cyc(20);
        resetn <= 1'b1;
        cyc(2);
        chk("irq_pin", {15'h0, irq_out_n}, 16'h0001);
        chk("led_mode", {14'h0, led_mode}, 16'h0000);
        ir(1'b0, 16'hFFFF);
        sr();
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            sr();
            sr();
        end
        pulse(8'hFF);
        sr();
        for (int k = 0; k < 8; k++) begin
            rs = lfsr(rs);
            @(posedge sys_clk);
            highest_common_mode <= k[2:0];
            {an_complete, an_enabled, local_side_pause, remote_partner_pause} <= rs[3:0];
            activity_led_n <= rs[4];
            cyc(3);
            sr();
        end
        tog(2);
        tog(2);
        sr();
        sr();
        ir(1'b0, 16'hFFFF);
        for (int i = 0; i < 3; i++) begin
            wc(16'h4100);
            tog(i);
            chk("irq_master", {15'h0, irq_out_n}, 16'h0001);
            ir(1'b0, 16'hFFFF);
            wc(16'h4000 | (16'h0800 >> i));
            tog(i);
            chk("irq_mask", {15'h0, irq_out_n}, 16'h0001);
            ir(1'b0, 16'hFFFF);
            wc(16'h4000);
            tog(i);
            chk("irq_low", {15'h0, irq_out_n}, 16'h0000);
            chk("tx_irq", {15'h0, tx_led_n}, 16'h0000);
            chk("rx_act", {15'h0, rx_led_n}, {15'h0, activity_led_n});
            chk("mode_int", {14'h0, led_mode}, 16'h0001);
            ir(1'b1, 16'hFFFF);
            cyc(3);
            ir(1'b0, 16'hFFFE);
            ir(1'b0, 16'hFFFF);
            chk("irq_high", {15'h0, irq_out_n}, 16'h0001);
        end
        rs = lfsr(rs);
        pan_sta_mgr_inst.wr(pan_pkg::REG_INT_CTRL_IDX, {2'b00, rs[13:0]});
        m_ctl = {2'b00, rs[13:8], 8'h00};
        cyc(2);
        ir(1'b0, 16'hFFFF);
        pan_sta_mgr_inst.wr(pan_pkg::REG_AN_STATUS_IDX, 16'hFFFF);
        sr();
        pan_sta_mgr_inst.rd(5'h1B, d, ok);
        chk("rvalid_unmapped", {15'h0, ok}, 16'h0000);
        wc(16'h8F00);
        for (int j = 0; j < 2; j++) begin
            @(posedge sys_clk);
            fdx_src_n <= j[0];
            cyc(3);
            chk("tx_fdx", {15'h0, tx_led_n}, {15'h0, j[0]});
            chk("mode_fdx", {14'h0, led_mode}, 16'h0002);
        end
        wc(16'h0F00);
        @(posedge sys_clk);
        {tx_src_n, rx_src_n} <= 2'b01;
        cyc(3);
        chk("leds_normal", {13'h0, tx_led_n, rx_led_n, |led_mode}, 16'h0002);
        conclude();
    end
endmodule // pan_regs_tb
`default_nettype wire
